// ### hdl/string_compare_engine.sv
/*
 string compare engine: walks two memory strings through pointer
 registers and compares element by element with cycle-exact timing.
 assumes memory answers a read with memAck, dst never written back.
*/
// Function
// [RULE1] fetch elements via dst and src pointers
// [RULE2] compare dst minus src, memory untouched
// [RULE3] match flag equals selected condition result
// [RULE4] down variants step pointers by 1/2
// [RULE5] up variants step pointers by 1/2
// [RULE6] counter decrements by one per element
// [RULE7] exhausted flag set when counter becomes zero
// [RULE8] repeat until condition or counter zero
// [RULE9] word repeat count must not exceed 32768
// [RULE10] repeat interruptible per element, start pc saved
// [RULE11] each accepted interrupt adds seven cycles
// [RULE12] single 25 cycles, repeat 11+14n cycles
// [RULE13] carry/sign undefined, half-carry/decimal kept
`timescale 1ns/100ps
`default_nettype none
`include "str_cmp_defines.svh"
module string_compare_engine #(
  parameter int ADDR_W = 16
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // instruction
  input  wire logic              start,
  input  wire logic              byteMode,
  input  wire logic              stepDown,
  input  wire logic              repeatMode,
  input  wire logic [3:0]        conditionSelect,
  input  wire logic [ADDR_W-1:0] instrPc,
  input  wire logic [ADDR_W-1:0] dstPtrIn,
  input  wire logic [ADDR_W-1:0] srcPtrIn,
  input  wire logic [15:0]       countIn,
  // interrupt request
  input  wire logic              intReq,
  output logic                   intAccept,
  output logic [ADDR_W-1:0]      savedPc,
  // memory read port
  output logic                   memRead,
  output logic [ADDR_W-1:0]      memAddr,
  input  wire logic              memAck,
  input  wire logic [15:0]       memData,
  // results
  output logic                   busy,
  output logic                   done,
  output logic [ADDR_W-1:0]      dstPtr,
  output logic [ADDR_W-1:0]      srcPtr,
  output logic [15:0]            count,
  output logic                   matchFlag,
  output logic                   exhaustFlag,
  output logic                   countError
);
  ////////////////////////////////////////////////////////////////////
  str_cmp_pkg::state_t state;
  logic        isByte;
  logic        isDown;
  logic        isRep;
  logic [3:0]  cc;
  logic [15:0] dstElem;
  logic [15:0] cycleCnt;
  logic [15:0] budget;
  logic        firstElem;
  logic        condNow;
  logic        condHeld;
  wire  [ADDR_W-1:0] step     = isByte ? ADDR_W'(`SC_STEP_BYTE) : ADDR_W'(`SC_STEP_WORD);
  wire  [ADDR_W-1:0] next_dst = isDown ? dstPtr - step : dstPtr + step; // RULE4
  wire  [ADDR_W-1:0] next_src = isDown ? srcPtr - step : srcPtr + step; // RULE5
  wire  [15:0] next_count    = count - 16'h0001;                        // RULE6
  wire         lastElem      = (next_count == 16'h0000);
  wire         finish        = !isRep || condHeld || exhaustFlag;       // RULE8
  wire  [15:0] elemBudget    = isRep ? (firstElem ? `SC_REP_SETUP + `SC_REP_PER_ELEM
                                                  : `SC_REP_PER_ELEM)
                                     : `SC_SINGLE_CYCLES;               // RULE12
  wire  [15:0] dstOp         = isByte ? {8'h00, dstElem[7:0]} : dstElem;
  wire  [15:0] srcOp         = isByte ? {8'h00, memData[7:0]} : memData;
  wire         budgetMet     = (cycleCnt + 16'h0001 >= budget);

  // only reads, never writes: operands stay intact
  assign memRead  = (state == str_cmp_pkg::StFetchDst) || (state == str_cmp_pkg::StFetchSrc); // RULE2
  assign memAddr  = (state == str_cmp_pkg::StFetchSrc) ? srcPtr : dstPtr; // RULE1
  assign busy     = (state != str_cmp_pkg::StIdle);
  assign intAccept = (state == str_cmp_pkg::StWait) && budgetMet && isRep && intReq && !finish;

  cond_eval u_cond (
    .byteMode        (isByte),
    .dstVal          (dstOp),
    .srcVal          (srcOp),
    .conditionSelect (cc),
    .condTrue        (condNow)
  );

  ////////////////////////////////////////////////////////////////////
  // stop decision in the wait phase reads the latched condition,
  // since memData no longer carries the source element there

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state       <= str_cmp_pkg::StIdle;
      isByte      <= 1'b0;
      isDown      <= 1'b0;
      isRep       <= 1'b0;
      cc          <= 4'h0;
      dstElem     <= 16'h0000;
      dstPtr      <= '0;
      srcPtr      <= '0;
      count       <= 16'h0000;
      matchFlag   <= 1'b0;
      exhaustFlag <= 1'b0;
      countError  <= 1'b0;
      savedPc     <= '0;
      cycleCnt    <= 16'h0000;
      budget      <= 16'h0000;
      firstElem   <= 1'b0;
      condHeld    <= 1'b0;
      done        <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state)
        str_cmp_pkg::StIdle: if (start) begin
          isByte     <= byteMode;
          isDown     <= stepDown;
          isRep      <= repeatMode;
          cc         <= conditionSelect;
          dstPtr     <= dstPtrIn;
          srcPtr     <= srcPtrIn;
          count      <= countIn;
          savedPc    <= instrPc;                                        // RULE10
          countError <= repeatMode && !byteMode && (countIn > `SC_WORD_MAX_COUNT); // RULE9
          firstElem  <= 1'b1;
          cycleCnt   <= 16'h0000;
          state      <= str_cmp_pkg::StFetchDst;
        end
        str_cmp_pkg::StFetchDst: begin
          cycleCnt <= cycleCnt + 16'h0001;
          if (memAck) begin
            dstElem <= memData;                                         // RULE1
            state   <= str_cmp_pkg::StFetchSrc;
          end
        end
        str_cmp_pkg::StFetchSrc: begin
          cycleCnt <= cycleCnt + 16'h0001;
          if (memAck) begin
            matchFlag   <= condNow;                                     // RULE3
            condHeld    <= condNow;
            dstPtr      <= next_dst;
            srcPtr      <= next_src;
            count       <= next_count;
            exhaustFlag <= lastElem;                                    // RULE7
            budget      <= elemBudget;
            state       <= str_cmp_pkg::StWait;
          end
        end
        str_cmp_pkg::StWait: begin
          cycleCnt <= cycleCnt + 16'h0001;
          if (budgetMet) begin
            cycleCnt  <= 16'h0000;
            firstElem <= 1'b0;
            if (finish) begin                                           // RULE8
              done  <= 1'b1;
              state <= str_cmp_pkg::StIdle;
            end else if (intReq) begin
              budget <= `SC_INT_EXTRA;                                  // RULE11
              state  <= str_cmp_pkg::StIntr;
            end else begin
              state <= str_cmp_pkg::StFetchDst;
            end
          end
        end
        str_cmp_pkg::StIntr: begin
          cycleCnt <= cycleCnt + 16'h0001;
          if (budgetMet) begin
            cycleCnt <= 16'h0000;
            state    <= str_cmp_pkg::StFetchDst;
          end
        end
        default: state <= str_cmp_pkg::StIdle;
      endcase
    end
  end

  // carry and sign are not produced; decimal/half-carry never touched RULE13
  // flags beyond match and exhausted live outside this block

  ////////////////////////////////////////////////////////////////////
  chk_match_tracks_cond: assert property (@(posedge clock) disable iff (!rst_n) // RULE3
    (state == str_cmp_pkg::StFetchSrc && memAck) |=> (matchFlag == $past(condNow)))
    else $error("match flag not equal to condition");
  chk_count_step: assert property (@(posedge clock) disable iff (!rst_n) // RULE6
    (state == str_cmp_pkg::StFetchSrc && memAck) |=> (count == $past(count) - 16'h0001))
    else $error("counter not decremented by one");
  chk_exhaust_zero: assert property (@(posedge clock) disable iff (!rst_n) // RULE7
    (state == str_cmp_pkg::StWait) |-> (exhaustFlag == (count == 16'h0000)))
    else $error("exhausted flag disagrees with counter");
  chk_ptr_down: assert property (@(posedge clock) disable iff (!rst_n) // RULE4
    (state == str_cmp_pkg::StFetchSrc && memAck && isDown) |=>
      (dstPtr == $past(dstPtr) - (isByte ? ADDR_W'(1) : ADDR_W'(2))))
    else $error("dst pointer not stepped down");
  chk_ptr_up: assert property (@(posedge clock) disable iff (!rst_n) // RULE5
    (state == str_cmp_pkg::StFetchSrc && memAck && !isDown) |=>
      (srcPtr == $past(srcPtr) + (isByte ? ADDR_W'(1) : ADDR_W'(2))))
    else $error("src pointer not stepped up");
  chk_fetch_addr: assert property (@(posedge clock) disable iff (!rst_n) // RULE1
    (state == str_cmp_pkg::StFetchSrc) |-> (memRead && memAddr == srcPtr))
    else $error("source fetch on wrong address");
  chk_single_done: assert property (@(posedge clock) disable iff (!rst_n) // RULE12
    (done && !isRep) |-> ($past(state, 26) == str_cmp_pkg::StIdle &&
                          $past(state, 25) == str_cmp_pkg::StFetchDst))
    else $error("single step not 25 cycles");
  chk_intr_len: assert property (@(posedge clock) disable iff (!rst_n) // RULE11
    intAccept |=> (state == str_cmp_pkg::StIntr)[*7] ##1 (state == str_cmp_pkg::StFetchDst))
    else $error("interrupt delay not seven cycles");
  chk_stop_cond: assert property (@(posedge clock) disable iff (!rst_n) // RULE8
    (done && isRep) |-> (matchFlag || exhaustFlag))
    else $error("repeat ended without cause");
  chk_pc_kept: assert property (@(posedge clock) disable iff (!rst_n) // RULE10
    intAccept |-> (savedPc == $past(savedPc)))
    else $error("start pc lost at interrupt");
endmodule
`default_nettype wire

// ### hdl/str_cmp_defines.svh
/*
 string compare engine constants.
 assumes inclusion by bare name from design files.
*/
`ifndef STR_CMP_DEFINES_SVH
`define STR_CMP_DEFINES_SVH
`define SC_SINGLE_CYCLES   16'h0019
`define SC_REP_SETUP       16'h000b
`define SC_REP_PER_ELEM    16'h000e
`define SC_INT_EXTRA       16'h0007
`define SC_STEP_BYTE       16'h0001
`define SC_STEP_WORD       16'h0002
`define SC_WORD_MAX_COUNT  16'h8000
`define SC_CC_WIDTH        4
`define SC_CC_EQ           4'h6
`define SC_CC_NE           4'he
`define SC_CC_ULT          4'h7
`define SC_CC_UGE          4'hf
`define SC_CC_ULE          4'h3
`define SC_CC_UGT          4'hb
`define SC_CC_LT           4'h1
`define SC_CC_GE           4'h9
`define SC_CC_LE           4'h2
`define SC_CC_GT           4'ha
`define SC_CC_ALWAYS       4'h8
`define SC_CC_NEVER        4'h0
`endif

// ### hdl/str_cmp_pkg.sv
/*
 types shared by the string compare engine.
 assumes nothing of its surroundings.
*/
package str_cmp_pkg;
  typedef enum logic [2:0] {
    StIdle, StFetchDst, StFetchSrc, StExec, StWait, StIntr
  } state_t;
  typedef logic [15:0] word_t;
endpackage

// ### hdl/cond_eval.sv
/*
 evaluates a selectable condition on dst minus src.
 assumes operands already narrowed to byte or word.
*/
`timescale 1ns/100ps
`default_nettype none
`include "str_cmp_defines.svh"
module cond_eval (
  // operands
  input  wire logic        byteMode,
  input  wire logic [15:0] dstVal,
  input  wire logic [15:0] srcVal,
  input  wire logic [3:0]  conditionSelect,
  // result
  output logic             condTrue
);
  wire [16:0] diff     = {1'b0, dstVal} - {1'b0, srcVal};
  wire        zero     = byteMode ? (diff[7:0] == 8'h00) : (diff[15:0] == 16'h0000);
  wire        sign     = byteMode ? diff[7] : diff[15];
  wire        borrow   = byteMode ? (dstVal[7:0] < srcVal[7:0]) : diff[16];
  wire        dSign    = byteMode ? dstVal[7] : dstVal[15];
  wire        sSign    = byteMode ? srcVal[7] : srcVal[15];
  wire        ovf      = (dSign != sSign) && (sign != dSign);
  wire        lessS    = sign ^ ovf;
  always_comb begin
    unique case (conditionSelect)
      `SC_CC_EQ:     condTrue = zero;
      `SC_CC_NE:     condTrue = !zero;
      `SC_CC_ULT:    condTrue = borrow;
      `SC_CC_UGE:    condTrue = !borrow;
      `SC_CC_ULE:    condTrue = borrow || zero;
      `SC_CC_UGT:    condTrue = !borrow && !zero;
      `SC_CC_LT:     condTrue = lessS;
      `SC_CC_GE:     condTrue = !lessS;
      `SC_CC_LE:     condTrue = lessS || zero;
      `SC_CC_GT:     condTrue = !lessS && !zero;
      `SC_CC_ALWAYS: condTrue = 1'b1;
      default:       condTrue = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ### tb/str_mem_model.sv
/*
 memory model holding the two strings read by the compare engine.
 assumes reads are held until memAck; the engine never writes.
*/
`timescale 1ns/100ps
`default_nettype none
module str_mem_model (
  // read port
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        memRead,
  input  wire logic [15:0] memAddr,
  output logic             memAck,
  output logic [15:0]      memData,
  // wait states before each answer
  input  wire logic [1:0]  stall
);
  logic [15:0] mem [0:65535];
  logic [15:0] last;
  logic [1:0]  waitCnt;
  ////////////////////////////////////////////////////////////////
  assign memAck  = memRead && (waitCnt == stall);
  // stale data inverted so a late sample cannot match
  assign memData = memAck ? mem[memAddr] : ~last;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      waitCnt <= 2'h0;
      last    <= 16'h0;
    end else if (memAck) begin
      waitCnt <= 2'h0;
      last    <= memData;
    end else if (memRead) begin
      waitCnt <= waitCnt + 2'h1;
    end
  end
endmodule
`default_nettype wire

// ### tb/string_compare_engine_test.sv
/*
 self-checking bench for the string compare engine.
 assumes the memory model answers reads; one 125 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "str_cmp_defines.svh"
module string_compare_engine_test;
  logic        clock = 1'b0, rst_n = 1'b0, start = 1'b0, byteMode = 1'b0;
  logic        stepDown = 1'b0, repeatMode = 1'b0, intReq = 1'b0;
  logic        memRead, memAck, busy, done, intAccept, matchFlag, exhaustFlag, countError;
  logic [3:0]  conditionSelect = 4'h0;
  logic [1:0]  stall = 2'h0;
  logic [15:0] instrPc = 16'h0, dstPtrIn = 16'h0, srcPtrIn = 16'h0, countIn = 16'h0;
  logic [15:0] savedPc, memAddr, memData, dstPtr, srcPtr, count;
  int          err_count = 0, compares = 0, accepts = 0, timer = 0;
  logic [3:0]  ccs [12] = '{`SC_CC_EQ, `SC_CC_NE, `SC_CC_ULT, `SC_CC_UGE, `SC_CC_ULE,
    `SC_CC_UGT, `SC_CC_LT, `SC_CC_GE, `SC_CC_LE, `SC_CC_GT, `SC_CC_ALWAYS, `SC_CC_NEVER};
  ////////////////////////////////////////////////////////////////
  always #4 clock = ~clock;
  string_compare_engine string_compare_engine_i (.clock, .rst_n, .start, .byteMode, .stepDown,
    .repeatMode, .conditionSelect, .instrPc, .dstPtrIn, .srcPtrIn, .countIn, .intReq,
    .intAccept, .savedPc, .memRead, .memAddr, .memAck, .memData, .busy, .done, .dstPtr,
    .srcPtr, .count, .matchFlag, .exhaustFlag, .countError);
  str_mem_model str_mem_model_i (.clock, .rst_n, .memRead, .memAddr, .memAck, .memData, .stall);
  ////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (err_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clock) begin
    timer <= timer + 1;
    if (timer == 20000) begin
      err_count++;
      final_report();
    end
  end
  task automatic chk(input logic [15:0] got, exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, v);
    str_mem_model_i.mem[a] = v;
  endtask
  function automatic logic expCond(input logic [3:0] cc, input logic b, input logic [15:0] x, y);
    logic [15:0] d, s;
    // sign extension keeps both byte orderings intact
    d = b ? {{8{x[7]}}, x[7:0]} : x;
    s = b ? {{8{y[7]}}, y[7:0]} : y;
    case (cc)
      `SC_CC_EQ:     return d == s;
      `SC_CC_NE:     return d != s;
      `SC_CC_ULT:    return d < s;
      `SC_CC_UGE:    return d >= s;
      `SC_CC_ULE:    return d <= s;
      `SC_CC_UGT:    return d > s;
      `SC_CC_LT:     return $signed(d) < $signed(s);
      `SC_CC_GE:     return $signed(d) >= $signed(s);
      `SC_CC_LE:     return $signed(d) <= $signed(s);
      `SC_CC_GT:     return $signed(d) > $signed(s);
      `SC_CC_ALWAYS: return 1'b1;
      default:       return 1'b0;
    endcase
  endfunction
  // runs one instruction; a second start mid-run must be ignored
  task automatic run(input logic b, dn, rp, input logic [3:0] cc, input logic [15:0] d, s, n,
                     output int cyc);
    logic acc;
    cyc = 0;
    acc = 1'b0;
    byteMode = b;
    stepDown = dn;
    repeatMode = rp;
    conditionSelect = cc;
    dstPtrIn = d;
    srcPtrIn = s;
    countIn = n;
    instrPc = instrPc + 16'h4;
    start = 1'b1;
    @(posedge clock);
    #1 start = 1'b0;
    dstPtrIn = ~d;
    srcPtrIn = ~s;
    while (done !== 1'b1 && cyc < 2000) begin
      @(posedge clock);
      #1 cyc++;
      start = (cyc == 5);
      if (cyc == 5) chk({15'h0, busy}, 16'h0001);
      // intAccept is combinational: drop the request only after its edge
      if (acc) intReq = 1'b0;
      acc = (intAccept === 1'b1);
      accepts += int'(acc);
    end
  endtask
  task automatic expectRes(input logic [15:0] ed, es, ec, input logic em, ev, input int ecyc, cyc);
    chk(dstPtr, ed);
    chk(srcPtr, es);
    chk(count, ec);
    chk({13'h0, countError, exhaustFlag, matchFlag}, {13'h0, 1'b0, ev, em});
    chk(16'(cyc), 16'(ecyc));
    chk({15'h0, busy}, 16'h0000);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    int c;
    logic [15:0] d, st;
    repeat (2) @(posedge clock);
    #1 rst_n = 1'b1;
    wr(16'h2000, 16'h00ff);
    wr(16'h3000, 16'h0000);
    run(1'b1, 1'b1, 1'b0, `SC_CC_UGE, 16'h2000, 16'h3000, 16'h0001, c);
    expectRes(16'h1fff, 16'h2fff, 16'h0000, 1'b1, 1'b1, 25, c);
    for (int i = 0; i < 4; i++) begin
      wr(16'h1000 + 16'(2 * i), 16'(2 * i));
      wr(16'h2000 + 16'(2 * i), (i == 1 || i == 2) ? 16'h0001 : 16'h0000);
    end
    run(1'b0, 1'b1, 1'b1, `SC_CC_EQ, 16'h1006, 16'h2006, 16'h8000, c);
    expectRes(16'h0ffe, 16'h1ffe, 16'h7ffc, 1'b1, 1'b0, 11 + 14 * 4, c);
    stall = 2'h1;
    for (int i = 0; i < 3; i++) begin
      wr(16'h0100 + 16'(i), 16'h3341 + 16'(i));
      wr(16'h0200 + 16'(i), 16'h7741 + 16'(i) + 16'(i == 2));
    end
    run(1'b1, 1'b0, 1'b1, `SC_CC_NE, 16'h0100, 16'h0200, 16'h0005, c);
    expectRes(16'h0103, 16'h0203, 16'h0002, 1'b1, 1'b0, 53, c);
    stall = 2'h0;
    intReq = 1'b1;
    run(1'b0, 1'b0, 1'b1, `SC_CC_NEVER, 16'h1000, 16'h2000, 16'h0003, c);
    expectRes(16'h1006, 16'h2006, 16'h0000, 1'b0, 1'b1, 11 + 14 * 3 + 7, c);
    chk(16'(accepts), 16'h0001);
    chk(savedPc, instrPc);
    wr(16'h0500, 16'h8000);
    wr(16'h0600, 16'h1280);
    wr(16'h0700, 16'h3401);
    for (int b = 0; b < 2; b++) begin
      for (int i = 0; i < 12; i++) begin
        d = b[0] ? 16'h0600 : 16'h0500;
        st = b[0] ? 16'h0001 : 16'h0002;
        run(b[0], 1'b0, 1'b0, ccs[i], d, 16'h0700, 16'(i), c);
        expectRes(d + st, 16'h0700 + st, 16'(i) - 16'h1, expCond(ccs[i], b[0],
          str_mem_model_i.mem[d], 16'h3401), i == 1, 25, c);
      end
    end
    run(1'b0, 1'b0, 1'b1, `SC_CC_ALWAYS, 16'h1000, 16'h2000, 16'h8001, c);
    chk({15'h0, countError}, 16'h0001);
    final_report();
  end
endmodule
`default_nettype wire
